// *** rtl/qbs_pkg.sv ***
// Shared constants and carrier types for the four-word burst separate-port SRAM block.
package qbs_pkg;

  // Width of one data word on the read and write ports.
  localparam int unsigned DATA_W = 18;
  // Width of one byte lane and number of byte lanes per word.
  localparam int unsigned BYTE_W = 9;
  localparam int unsigned BE_W = 2;
  // Address pins on the shared address bus.
  localparam int unsigned ADDR_W = 20;
  // Words per burst and bits that index a word inside a burst.
  localparam int unsigned BURST_LEN = 4;
  localparam int unsigned IDX_W = 2;
  // Word address: burst address with the word index appended.
  localparam int unsigned WADDR_W = ADDR_W + IDX_W;

  // Word positions inside a burst.
  localparam logic [IDX_W-1:0] WORD0 = 2'h0;
  localparam logic [IDX_W-1:0] WORD1 = 2'h1;
  localparam logic [IDX_W-1:0] WORD2 = 2'h2;
  localparam logic [IDX_W-1:0] WORD3 = 2'h3;

  // Read latency in half clock cycles for each setting of the latency pin.
  localparam int unsigned RD_LAT_LONG_HALVES = 5;
  localparam int unsigned RD_LAT_SHORT_HALVES = 2;

  // Reset values of the control state.
  localparam logic SLOT_READ_RST = 1'b1;
  localparam logic LAT_LONG_RST = 1'b0;
  localparam logic HOLD_RST = 1'b1;

  // An address command captured from the shared bus.
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
  } qbs_cmd_t;

  // One selected word of a burst.
  typedef struct packed {
    logic valid;
    logic [WADDR_W-1:0] waddr;
  } qbs_wsel_t;

  // One captured write beat waiting for its array update.
  typedef struct packed {
    logic valid;
    logic [WADDR_W-1:0] waddr;
    logic [DATA_W-1:0] data;
    logic [BE_W-1:0] be_n;
  } qbs_beat_t;

  // A staged read beat for the complement-clock output register.
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } qbs_rbeat_t;

endpackage : qbs_pkg

// *** rtl/qbs_sram_port.sv ***
// Separate read/write port burst SRAM with double-data-rate data ports and echo clocks.
//
// Contract
// - Separate read outputs and write inputs, no turnaround.
// - Shared address bus, alternating read/write capture edges.
// - Each address holds four words, moved as burst.
// - Data moves on rising edges of both clocks.
// - Latency pin high: read data after 2.5 cycles.
// - Latency pin low: read data after one cycle.
// - Read and write ports run fully independently.
// - Each port has its own select input.
// - Inputs captured in registers on either input clock.
// - Read outputs driven from registers on input clocks.
// - Array writes are self-timed inside the device.
// - Valid flag marks phases carrying read data.
// - Complementary echo clocks accompany read data.
// - Only rising edges of input clocks matter.
// - Reads return the newest written data.
// - Active-low write select starts write, else ignored.
// - Byte selects gate bits 8:0 and 17:9.
// - Read outputs float when the read port is idle; here o_read_data drives zero and o_read_data_oe goes low.
module qbs_sram_port #(
  parameter int unsigned ARRAY_ADDR_W = qbs_pkg::ADDR_W
) (
  // System clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_reset,
  // Complementary input clocks from the host.
  input wire logic i_k_clk,
  input wire logic i_kn_clk,
  // Static latency strap.
  input wire logic i_latency_select_pin,
  // Port selects and shared address bus.
  input wire logic i_read_port_select_n,
  input wire logic i_write_port_select_n,
  input wire logic [qbs_pkg::ADDR_W-1:0] i_addr,
  // Write data port.
  input wire logic [qbs_pkg::DATA_W-1:0] i_write_data,
  input wire logic [qbs_pkg::BE_W-1:0] i_byte_write_select_n,
  // Read data port.
  output logic [qbs_pkg::DATA_W-1:0] o_read_data,
  output logic o_read_data_oe,
  output logic o_read_valid_flag,
  output logic o_echo_clock,
  output logic o_echo_clock_n,
  // System-side status.
  output logic o_link_ready
);
  import qbs_pkg::*;

  // Array index width: burst address bits plus the word index.
  localparam int unsigned MEM_IDX_W = ARRAY_ADDR_W + IDX_W;

  // The array: four words per burst address.
  logic [DATA_W-1:0] mem [0:(1 << MEM_IDX_W)-1];

  // Merges new data into an old word, keeping the lanes whose select is high.
  function automatic logic [DATA_W-1:0] merge_word(input logic [DATA_W-1:0] old_w, input qbs_beat_t b);
    logic [DATA_W-1:0] r;
    r = old_w;
    if (!b.be_n[0])
    begin
      r[BYTE_W-1:0] = b.data[BYTE_W-1:0];
    end
    if (!b.be_n[1])
    begin
      r[DATA_W-1:BYTE_W] = b.data[DATA_W-1:BYTE_W];
    end
    return r;
  endfunction : merge_word

  // Picks the word of whichever of two staged commands is live.
  function automatic qbs_wsel_t pick_word(input qbs_cmd_t a, input qbs_cmd_t b,
                                          input logic [IDX_W-1:0] ia, input logic [IDX_W-1:0] ib);
    qbs_wsel_t s;
    s.valid = a.valid | b.valid;
    s.waddr = a.valid ? {a.addr, ia} : {b.addr, ib};
    return s;
  endfunction : pick_word

  // System domain: strap synchroniser, strap capture, link reset hold.
  logic lat_meta_reg;
  logic lat_sync_reg;
  logic cap_done_reg;
  logic lat_long_reg;
  logic link_hold_reg;
  logic ready_meta_reg;
  logic ready_sync_reg;

  // Link domain state on the true clock.
  logic k_rst_meta_reg;
  logic k_rst_reg;
  logic k_lat_meta_reg;
  logic k_lat_reg;
  logic rd_slot_reg; // High when the coming edge takes a read address.
  qbs_cmd_t rd_s0_reg; // Read commands by age in cycles.
  qbs_cmd_t rd_s1_reg;
  qbs_cmd_t rd_s2_reg;
  qbs_cmd_t rd_s3_reg;
  qbs_cmd_t wr_s0_reg; // Write commands by age in cycles.
  qbs_cmd_t wr_s1_reg;
  qbs_cmd_t wr_s2_reg;
  qbs_beat_t k_pend_reg; // Write beat caught on the true clock.
  logic [DATA_W-1:0] k_out_reg;
  logic k_valid_reg;
  logic k_cq_reg;
  qbs_rbeat_t kn_stage_reg; // Beat handed to the complement clock.

  // Link domain state on the complement clock.
  qbs_beat_t kn_pend_reg;
  logic [DATA_W-1:0] kn_out_reg;
  logic kn_valid_reg;
  logic kn_cq_reg;

  // Address capture qualifiers for the alternating slots.
  wire rd_accept = !k_rst_reg && rd_slot_reg && !i_read_port_select_n;
  wire wr_accept = !k_rst_reg && !rd_slot_reg && !i_write_port_select_n;

  // Word selection for each read and write beat position.
  wire qbs_wsel_t k_rd_sel = k_lat_reg ? pick_word(rd_s2_reg, rd_s3_reg, WORD1, WORD3)
                                       : pick_word(rd_s0_reg, rd_s1_reg, WORD0, WORD2);
  wire qbs_wsel_t kn_rd_sel = k_lat_reg ? pick_word(rd_s1_reg, rd_s2_reg, WORD0, WORD2)
                                        : pick_word(rd_s0_reg, rd_s1_reg, WORD1, WORD3);
  wire qbs_wsel_t k_wr_sel = pick_word(wr_s0_reg, wr_s1_reg, WORD0, WORD2);
  wire qbs_wsel_t kn_wr_sel = pick_word(wr_s1_reg, wr_s2_reg, WORD1, WORD3);

  // Array index of each selected word.
  wire [MEM_IDX_W-1:0] k_rd_idx = k_rd_sel.waddr[MEM_IDX_W-1:0];
  wire [MEM_IDX_W-1:0] kn_rd_idx = kn_rd_sel.waddr[MEM_IDX_W-1:0];
  wire [MEM_IDX_W-1:0] k_pend_idx = k_pend_reg.waddr[MEM_IDX_W-1:0];
  wire [MEM_IDX_W-1:0] kn_pend_idx = kn_pend_reg.waddr[MEM_IDX_W-1:0];

  // Reads a word through both pending beats so an update in flight is seen.
  // All it looks at arrives as arguments, so the wires below follow array and beat changes too.
  function automatic logic [DATA_W-1:0] read_word(input logic [DATA_W-1:0] base, input logic [MEM_IDX_W-1:0] idx,
                                                  input qbs_beat_t kp, input qbs_beat_t knp);
    logic [DATA_W-1:0] v;
    v = base;
    if (kp.valid && kp.waddr[MEM_IDX_W-1:0] == idx)
    begin
      v = merge_word(v, kp);
    end
    if (knp.valid && knp.waddr[MEM_IDX_W-1:0] == idx)
    begin
      v = merge_word(v, knp);
    end
    return v;
  endfunction : read_word

  wire [DATA_W-1:0] k_rd_word = read_word(mem[k_rd_idx], k_rd_idx, k_pend_reg, kn_pend_reg);
  wire [DATA_W-1:0] kn_rd_word = read_word(mem[kn_rd_idx], kn_rd_idx, k_pend_reg, kn_pend_reg);

  // First strap flop feeds only the second; neither takes a reset.
  always_ff @(posedge i_sys_clk)
  begin
    lat_meta_reg <= i_latency_select_pin;
    lat_sync_reg <= lat_meta_reg;
  end

  // Catch the strap once after reset release, then free the link one cycle later.
  // The extra cycle lets the mode settle before the hold starts its own crossing.
  // The strap is not meant to change in operation, so it is sampled only here.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      cap_done_reg <= 1'b0;
      lat_long_reg <= LAT_LONG_RST;
      link_hold_reg <= HOLD_RST;
    end
    else
    begin
      cap_done_reg <= 1'b1;
      lat_long_reg <= cap_done_reg ? lat_long_reg : lat_sync_reg;
      link_hold_reg <= !cap_done_reg;
    end
  end

  // Link readiness comes back through two synchroniser flops and an output register.
  always_ff @(posedge i_sys_clk)
  begin
    ready_meta_reg <= !k_rst_reg;
    ready_sync_reg <= ready_meta_reg;
    o_link_ready <= i_reset ? 1'b0 : ready_sync_reg;
  end

  // Reset hold and latency mode enter the link domain through two flops each.
  // The mode is settled before the hold drops, so its crossing is safe.
  always_ff @(posedge i_k_clk)
  begin
    k_rst_meta_reg <= link_hold_reg;
    k_rst_reg <= k_rst_meta_reg;
    k_lat_meta_reg <= lat_long_reg;
    k_lat_reg <= k_lat_meta_reg;
  end

  // Command pipeline: the address bus is registered on the true clock only.
  always_ff @(posedge i_k_clk)
  begin
    if (k_rst_reg)
    begin
      rd_slot_reg <= SLOT_READ_RST;
      rd_s0_reg <= '0;
      rd_s1_reg <= '0;
      rd_s2_reg <= '0;
      rd_s3_reg <= '0;
      wr_s0_reg <= '0;
      wr_s1_reg <= '0;
      wr_s2_reg <= '0;
    end
    else
    begin
      rd_slot_reg <= !rd_slot_reg;
      rd_s0_reg <= '{valid: rd_accept, addr: i_addr};
      rd_s1_reg <= rd_s0_reg;
      rd_s2_reg <= rd_s1_reg;
      rd_s3_reg <= rd_s2_reg;
      wr_s0_reg <= '{valid: wr_accept, addr: i_addr};
      wr_s1_reg <= wr_s0_reg;
      wr_s2_reg <= wr_s1_reg;
    end
  end

  // Write beats 0 and 2 land in input registers on the true clock.
  always_ff @(posedge i_k_clk)
  begin
    if (k_rst_reg)
    begin
      k_pend_reg <= '0;
    end
    else
    begin
      k_pend_reg <= '{valid: k_wr_sel.valid, waddr: k_wr_sel.waddr,
                      data: i_write_data, be_n: i_byte_write_select_n};
    end
  end

  // Write beats 1 and 3 land in input registers on the complement clock.
  always_ff @(posedge i_kn_clk)
  begin
    if (k_rst_reg)
    begin
      kn_pend_reg <= '0;
    end
    else
    begin
      kn_pend_reg <= '{valid: kn_wr_sel.valid, waddr: kn_wr_sel.waddr,
                       data: i_write_data, be_n: i_byte_write_select_n};
    end
  end

  // Self-timed array update: every captured beat commits at the next true edge.
  // The complement beat is newer, so it is applied last.
  always_ff @(posedge i_k_clk)
  begin
    if (k_pend_reg.valid)
    begin
      mem[k_pend_idx] <= merge_word(mem[k_pend_idx], k_pend_reg);
    end
    if (kn_pend_reg.valid)
    begin
      mem[kn_pend_idx] <= merge_word(mem[kn_pend_idx], kn_pend_reg);
    end
  end

  // Read output registers on the true clock, plus the staged complement beat.
  always_ff @(posedge i_k_clk)
  begin
    if (k_rst_reg)
    begin
      k_out_reg <= '0;
      k_valid_reg <= 1'b0;
      k_cq_reg <= 1'b0;
      kn_stage_reg <= '0;
    end
    else
    begin
      k_out_reg <= k_rd_sel.valid ? k_rd_word : '0;
      k_valid_reg <= k_rd_sel.valid;
      k_cq_reg <= 1'b1;
      kn_stage_reg <= '{valid: kn_rd_sel.valid, data: kn_rd_sel.valid ? kn_rd_word : '0};
    end
  end

  // Read output registers on the complement clock.
  always_ff @(posedge i_kn_clk)
  begin
    if (k_rst_reg)
    begin
      kn_out_reg <= '0;
      kn_valid_reg <= 1'b0;
      kn_cq_reg <= 1'b0;
    end
    else
    begin
      kn_out_reg <= kn_stage_reg.data;
      kn_valid_reg <= kn_stage_reg.valid;
      kn_cq_reg <= 1'b1;
    end
  end

  // Double-rate output select: the true clock level picks the register of the last edge.
  // This one level of muxing is the price of a register-only model of a double-rate pin.
  assign o_read_data = i_k_clk ? k_out_reg : kn_out_reg;
  assign o_read_valid_flag = i_k_clk ? k_valid_reg : kn_valid_reg;
  assign o_read_data_oe = i_k_clk ? k_valid_reg : kn_valid_reg;
  assign o_echo_clock = i_k_clk & k_cq_reg;
  assign o_echo_clock_n = !i_k_clk & kn_cq_reg;

  // Steps of a read burst for each latency setting.
  sequence s_short_burst;
    ##1 (k_valid_reg && kn_stage_reg.valid) ##1 (k_valid_reg && kn_stage_reg.valid);
  endsequence
  sequence s_long_burst;
    ##2 kn_stage_reg.valid ##1 (k_valid_reg && kn_stage_reg.valid) ##1 k_valid_reg;
  endsequence

  // Helper copy of a full-word write beat for the landing check.
  logic chk_full_reg;
  logic [MEM_IDX_W-1:0] chk_idx_reg;
  logic [DATA_W-1:0] chk_data_reg;
  always_ff @(posedge i_k_clk)
  begin
    chk_full_reg <= k_pend_reg.valid && k_pend_reg.be_n == '0 && !(kn_pend_reg.valid && kn_pend_idx == k_pend_idx);
    chk_idx_reg <= k_pend_idx;
    chk_data_reg <= k_pend_reg.data;
  end

  a_slot_alternate: assert property (@(posedge i_k_clk) disable iff (k_rst_reg)
    rd_slot_reg |=> !rd_slot_reg)
    else $error("Address slots did not alternate.");

  a_short_latency: assert property (@(posedge i_k_clk) disable iff (k_rst_reg)
    (rd_accept && !k_lat_reg) |=> s_short_burst)
    else $error("Short latency read burst misplaced.");

  a_long_latency: assert property (@(posedge i_k_clk) disable iff (k_rst_reg)
    (rd_accept && k_lat_reg) |=> s_long_burst)
    else $error("Long latency read burst misplaced.");

  a_idle_no_access: assert property (@(posedge i_k_clk) disable iff (k_rst_reg)
    (!rd_accept && !wr_accept) |=> (!rd_s0_reg.valid && !wr_s0_reg.valid))
    else $error("Access started without a select.");

  a_write_beats: assert property (@(posedge i_k_clk) disable iff (k_rst_reg)
    wr_accept |=> ##1 k_pend_reg.valid ##1 k_pend_reg.valid)
    else $error("Write burst beats not captured.");

  a_write_lands: assert property (@(posedge i_k_clk) disable iff (k_rst_reg)
    chk_full_reg |-> mem[chk_idx_reg] == chk_data_reg)
    else $error("Write beat did not reach the array.");

  a_kn_capture: assert property (@(posedge i_kn_clk) disable iff (k_rst_reg)
    wr_s1_reg.valid |=> kn_pend_reg.valid)
    else $error("Complement clock write beat lost.");

  a_idle_tristate: assert property (@(posedge i_k_clk) disable iff (k_rst_reg)
    (!rd_s0_reg.valid && !rd_s1_reg.valid && !rd_s2_reg.valid && !rd_s3_reg.valid) |=> !k_valid_reg)
    else $error("Read outputs driven while idle.");

  a_bypass_read: assert property (@(posedge i_k_clk) disable iff (k_rst_reg)
    (k_rd_sel.valid && k_pend_reg.valid && k_pend_idx == k_rd_idx && k_pend_reg.be_n == '0
     && !(kn_pend_reg.valid && kn_pend_idx == k_rd_idx)) |=> k_out_reg == $past(k_pend_reg.data))
    else $error("Read missed a pending write.");

endmodule : qbs_sram_port

// *** test/qbs_host_model.sv ***
// Host controller model: input clocks, port selects, shared address bus and write beats.
module qbs_host_model (
  // Clocks toward the device.
  output logic o_k_clk,
  output logic o_kn_clk,
  // Commands and write beats.
  output logic o_rd_sel_n,
  output logic o_wr_sel_n,
  output logic [qbs_pkg::ADDR_W-1:0] o_addr,
  output logic [qbs_pkg::DATA_W-1:0] o_wdata,
  output logic [qbs_pkg::BE_W-1:0] o_be_n,
  // Valid flag from the device, used only to find the slot phase.
  input wire logic i_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  import qbs_pkg::*;
  logic next_rd; // High when the coming K rise is a read slot.

  // Idle levels at time zero.
  initial
  begin
    o_k_clk = 1'b0;
    o_kn_clk = 1'b1;
    o_rd_sel_n = 1'b1;
    o_wr_sel_n = 1'b1;
    o_addr = '0;
    o_wdata = '0;
    o_be_n = '1;
    next_rd = 1'b0;
  end

  // Free-running complementary clocks, 12 ns period.
  always #6
  begin
    o_k_clk = ~o_k_clk;
    o_kn_clk = ~o_k_clk;
  end

  // Slots alternate on every K rise.
  always @(posedge o_k_clk) next_rd <= ~next_rd;

  // Waits until the coming K rise has the wanted kind; drives just after an edge.
  task automatic to_slot(input logic rd);
    @(posedge o_k_clk);
    #2;
    while (next_rd !== rd)
    begin
      @(posedge o_k_clk);
      #2;
    end
  endtask : to_slot

  // One read request; the bus shows junk once the edge is past, never the old address.
  task automatic read_burst(input logic [ADDR_W-1:0] a, input logic en);
    to_slot(1'b1);
    o_rd_sel_n = ~en;
    o_addr = a;
    @(posedge o_k_clk);
    #1;
    o_rd_sel_n = 1'b1;
    o_addr = ~a;
  endtask : read_burst

  // One write request, then four beats on K and K# rises, starting one K cycle later.
  task automatic write_burst(input logic [ADDR_W-1:0] a, input logic en,
                             input logic [4*DATA_W-1:0] d, input logic [4*BE_W-1:0] be);
    to_slot(1'b0);
    o_wr_sel_n = ~en;
    o_addr = a;
    @(posedge o_k_clk);
    #1;
    o_wr_sel_n = 1'b1;
    o_addr = ~a;
    #9;
    o_wdata = d[DATA_W-1:0];
    o_be_n = be[BE_W-1:0];
    @(posedge o_k_clk);
    for (int i = 1; i < 5; i++)
    begin
      #3;
      o_wdata = (i < 4) ? d[i*DATA_W +: DATA_W] : ~o_wdata;
      o_be_n = (i < 4) ? be[i*BE_W +: BE_W] : ~o_be_n;
      if (i < 4)
        @(posedge o_k_clk or posedge o_kn_clk);
    end
  endtask : write_burst

  // Probes one edge with a read; whether beats follow tells which phase the slots have.
  task automatic calibrate;
    logic seen;
    logic r0;
    seen = 1'b0;
    @(posedge o_k_clk);
    #2;
    o_rd_sel_n = 1'b0;
    @(posedge o_k_clk);
    #1;
    r0 = next_rd;
    o_rd_sel_n = 1'b1;
    repeat (12)
    begin
      @(posedge o_k_clk or posedge o_kn_clk);
      #3;
      if (i_valid === 1'b1)
        seen = 1'b1;
    end
    if (seen === r0)
      next_rd = ~next_rd;
  endtask : calibrate
endmodule : qbs_host_model

// *** test/tb_top.sv ***
// Self-checking bench: both latency settings, bursts, byte lanes, deselects, overlap.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import qbs_pkg::*;
  // One expected read beat: half-cycle count when due, and its data.
  typedef struct packed {
    logic [31:0] h;
    logic [DATA_W-1:0] d;
  } qbs_tb_note_t;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic lat_pin = 1'b0;
  logic cal = 1'b1; // Read port is not judged while the slot phase is probed.
  wire k_clk, kn_clk, rd_sel_n, wr_sel_n;
  wire [ADDR_W-1:0] addr;
  wire [DATA_W-1:0] wdata, rdata;
  wire [BE_W-1:0] be_n;
  wire oe, vld, eck, eck_n, ready;
  int miscompares = 0;
  int n_compared = 0;
  int hc = 0;
  int cycles = 0;
  logic [31:0] rnd = 32'h078a;
  qbs_tb_note_t notes[$];
  logic [DATA_W-1:0] mem [0:255]; // Shadow of the six-bit deep array, four words a place.

  qbs_sram_port #(.ARRAY_ADDR_W(6)) DUT (
    .i_sys_clk(sys_clk), .i_reset(reset), .i_k_clk(k_clk), .i_kn_clk(kn_clk),
    .i_latency_select_pin(lat_pin), .i_read_port_select_n(rd_sel_n),
    .i_write_port_select_n(wr_sel_n), .i_addr(addr), .i_write_data(wdata),
    .i_byte_write_select_n(be_n), .o_read_data(rdata), .o_read_data_oe(oe),
    .o_read_valid_flag(vld), .o_echo_clock(eck), .o_echo_clock_n(eck_n), .o_link_ready(ready));
  qbs_host_model host (
    .o_k_clk(k_clk), .o_kn_clk(kn_clk), .o_rd_sel_n(rd_sel_n), .o_wr_sel_n(wr_sel_n),
    .o_addr(addr), .o_wdata(wdata), .o_be_n(be_n), .i_valid(vld));

  // System clock, 100 ns period.
  always #50 sys_clk = ~sys_clk;

  // Cuts a hang short; the whole run needs well under a hundred cycles.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      miscompares++;
      final_report();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // Burst address with random upper bits, which alias in the shallow array.
  function automatic logic [ADDR_W-1:0] ad(input int i);
    rnd = lfsr(rnd);
    return {rnd[13:0], i[5:0]};
  endfunction : ad

  task automatic miss(input string m);
    miscompares++;
    $display("MISMATCH %0t %s", $time, m);
  endtask : miss

  task automatic final_report;
    if (miscompares == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report

  // Random burst; the shadow takes only enabled lanes of a selected write.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic en, input logic [7:0] be);
    logic [4*DATA_W-1:0] d;
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      d[i*DATA_W +: DATA_W] = rnd[DATA_W-1:0];
      for (int b = 0; b < BE_W; b++)
        if (en && !be[i*BE_W+b])
          mem[{a[5:0], i[1:0]}][b*BYTE_W +: BYTE_W] = d[i*DATA_W+b*BYTE_W +: BYTE_W];
    end
    host.write_burst(a, en, d, be);
  endtask : wr

  // Read request; notes four beats due from the capture edge on.
  task automatic rd(input logic [ADDR_W-1:0] a, input logic en);
    int h;
    host.read_burst(a, en);
    h = hc + (lat_pin ? RD_LAT_LONG_HALVES : RD_LAT_SHORT_HALVES);
    for (int i = 0; i < 4; i++)
      if (en)
        notes.push_back('{h + i, mem[{a[5:0], i[1:0]}]});
  endtask : rd

  // Counts input clock rises so that beats are pinned to their half cycle.
  always @(posedge k_clk or posedge kn_clk) hc++;

  // Judges the read port shortly after every input clock rise.
  always @(posedge k_clk or posedge kn_clk)
  begin
    qbs_tb_note_t note;
    #3;
    if (!cal && ready === 1'b1)
    begin
      n_compared += 2;
      if (eck !== k_clk || eck_n !== kn_clk) miss("echo clocks");
      if (vld === 1'b1 && notes.size() == 0) miss("unexpected read beat");
      else if (vld === 1'b1)
      begin
        note = notes.pop_front();
        if (note.h !== hc || rdata !== note.d || oe !== 1'b1) miss("read beat");
      end
      else if (vld !== 1'b0 || oe !== 1'b0) miss("idle read port");
    end
  end

  // Main sequence, once with short latency and once with long, each after a reset.
  initial
  begin
    for (int p = 0; p < 2; p++)
    begin
      @(negedge sys_clk);
      cal = 1'b1;
      reset = 1'b1;
      lat_pin = p[0];
      repeat (6) @(negedge sys_clk);
      reset = 1'b0;
      for (int w = 0; w < 50 && ready !== 1'b1; w++)
        @(negedge sys_clk);
      n_compared++;
      if (ready !== 1'b1) miss("link not ready");
      host.calibrate();
      cal = 1'b0;
      // Writes in every second write slot, then back-to-back reads of the same places.
      for (int i = 0; i < 8; i++)
        wr(ad(i), 1'b1, 8'h00);
      for (int i = 0; i < 8; i++)
        rd(ad(i), 1'b1);
      // Every lane pattern in one burst, with a read running alongside.
      fork
        wr(ad(1), 1'b1, 8'h1b);
        rd(ad(2), 1'b1);
      join
      // Both ports deselected in their slots.
      fork
        wr(ad(3), 1'b0, 8'h00);
        rd(ad(1), 1'b0);
      join
      fork
        rd(ad(1), 1'b1);
        wr(ad(4), 1'b1, 8'h00);
      join
      rd(ad(3), 1'b1);
      // Read in the slot right after a write to the same place; with short latency its beats still await the array.
      fork
        wr(ad(5), 1'b1, 8'h00);
        begin
          @(posedge k_clk);
          rd(ad(5), 1'b1);
        end
      join
      repeat (10) @(posedge k_clk);
      n_compared++;
      if (notes.size() != 0) miss("read beats missing");
    end
    final_report();
  end
endmodule : tb_top
